/* File: src/picc_controller.sv */
// Priority interrupt controller with AHB-Lite register slave
//
// Operation
// - Two control modes are chosen by a two-bit mode field in the system control register.
// - The non-maskable request ranks at level 8, above every settable level, and is never masked at cpu_req; its status bit reaches irq_out only through mask bit 6.
// - Each source presents its own distinct vector number.
// - The non-maskable pin detects its rising or its falling edge, chosen by a control bit.
// - Each of six external pins senses falling edge, rising edge, both edges or low level.
// - Ten priority registers each hold two 3-bit level fields at bits 2..0 and 6..4.
// - Field code 000 is level 0, the lowest, and 111 is level 7, the highest.
// - Bits 7 and 3 of each priority register always read zero.
// - Every priority field resets to all ones, level 7.
// - The enable register holds one enable per external pin at bits 5..0, reset to zero.
// - The lowest address bits are ignored and taken as zero for word accesses.
// - Sense code 00 is low level, 01 falling, 10 rising and 11 both edges.
// - A pin's flag is set whenever its selected sense condition occurs.
`timescale 1ns/10ps
`default_nettype none
module picc_controller
  import picc_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  nmi_pin,
  input  wire logic [NUM_EXT-1:0]    external_request_pins,
  input  wire logic [NUM_PERIPH-1:0] periph_req,
  input  wire logic                  cpu_ack,
  output logic                       cpu_req,
  output logic [6:0]                 cpu_vector,
  output logic [3:0]                 cpu_level,
  output logic                       irq_out
);

  // Register state
  picc_bus_state_type bus_state_reg, bus_state_next;
  logic [5:0]         addr_reg, addr_next;
  logic               addr_ok_reg, addr_ok_next;
  logic [31:0]        hrdata_reg, hrdata_next;
  logic               hreadyout_reg, hreadyout_next;
  logic               hresp_reg;
  logic [1:0]         mode_reg, mode_next;
  logic               nmi_rise_reg, nmi_rise_next;
  logic [1:0]         sense_reg [NUM_EXT];
  logic [1:0]         sense_next [NUM_EXT];
  logic [2:0]         prio_reg [NUM_SRC];
  logic [2:0]         prio_next [NUM_SRC];
  logic [5:0]         enable_reg, enable_next;
  logic [5:0]         flag_reg, flag_next;
  logic [6:0]         mask_reg, mask_next;
  logic [6:0]         status_reg, status_next;
  logic               nmi_pend_reg, nmi_pend_next;
  logic               cpu_req_reg, cpu_req_next;
  logic [6:0]         cpu_vector_reg, cpu_vector_next;
  logic [3:0]         cpu_level_reg, cpu_level_next;
  logic               irq_out_reg, irq_out_next;

  logic               take;
  logic               wr_en;
  logic [7:0]         wr_byte;
  logic [7:0]         wr_ofs;
  logic [31:0]        rd_value;
  logic [NUM_EXT-1:0] ext_hit;
  logic               nmi_hit;
  logic [NUM_SRC-1:0] src_req;
  logic               mode2;

  assign take    = hsel & hready & htrans[1];
  assign wr_en   = (bus_state_reg == PICC_BUS_WRITE) & addr_ok_reg;
  assign wr_byte = hwdata[7:0];
  assign wr_ofs  = {addr_reg, 2'b00};
  assign mode2   = (mode_reg == MODE_SEL_2);

  // Pin detectors, one per external pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
      picc_sense_detect u_det (
        .clk       (hclk),
        .rst_n     (hresetn),
        .pin_level (external_request_pins[gi]),
        .sense_sel (sense_reg[gi]),
        .event_hit (ext_hit[gi])
      );
    end
  endgenerate

  // Non-maskable pin: only the two single-edge codes are ever selected
  picc_sense_detect u_nmi_det (
    .clk       (hclk),
    .rst_n     (hresetn),
    .pin_level (nmi_pin),
    .sense_sel (nmi_rise_reg ? SENSE_RISE : SENSE_FALL),
    .event_hit (nmi_hit)
  );

  // Bus slave: writes finish with zero wait, reads add one wait so a write just before is seen
  always_comb begin
    bus_state_next = bus_state_reg;
    addr_next      = addr_reg;
    addr_ok_next   = addr_ok_reg;
    hrdata_next    = hrdata_reg;
    hreadyout_next = 1'b1;
    case (bus_state_reg)
      PICC_BUS_RDWAIT: begin
        hrdata_next    = rd_value;
        bus_state_next = PICC_BUS_IDLE;
      end
      default: begin
        bus_state_next = PICC_BUS_IDLE;
        if (take) begin
          addr_next    = haddr[7:2];
          addr_ok_next = (haddr[31:8] == 24'h000000);
          if (hwrite) begin
            bus_state_next = PICC_BUS_WRITE;
          end else begin
            bus_state_next = PICC_BUS_RDWAIT;
            hreadyout_next = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_reg <= PICC_BUS_IDLE;
      addr_reg      <= 6'h00;
      addr_ok_reg   <= 1'b0;
      hrdata_reg    <= 32'h00000000;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else begin
      bus_state_reg <= bus_state_next;
      addr_reg      <= addr_next;
      addr_ok_reg   <= addr_ok_next;
      hrdata_reg    <= hrdata_next;
      hreadyout_reg <= hreadyout_next;
      hresp_reg     <= 1'b0;
    end
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    rd_value = 32'h00000000;
    if (addr_ok_reg) begin
      case (wr_ofs)
        OFS_SYSTEM_CONTROL: rd_value[2:0] = {nmi_rise_reg, mode_reg};
        OFS_SENSE_HIGH:     rd_value[3:0] = {sense_reg[5], sense_reg[4]};
        OFS_SENSE_LOW:      rd_value[7:0] = {sense_reg[3], sense_reg[2], sense_reg[1], sense_reg[0]};
        OFS_REQ_ENABLE:     rd_value[5:0] = enable_reg;
        OFS_REQ_FLAG:       rd_value[5:0] = flag_reg;
        OFS_INT_MASK:       rd_value[6:0] = mask_reg;
        OFS_INT_STATUS:     rd_value[6:0] = status_reg;
        OFS_PRESENTED:      rd_value[12:0] = {cpu_req_reg, cpu_level_reg, 1'b0, cpu_vector_reg};
        default: begin
          if (wr_ofs >= OFS_PRIO_FIRST && wr_ofs <= OFS_PRIO_LAST) begin
            rd_value[7:0] = {1'b0, prio_reg[2 * (addr_reg - 6'h10)],
                             1'b0, prio_reg[2 * (addr_reg - 6'h10) + 1]};
          end
        end
      endcase
    end
  end

  // Configuration registers
  always_comb begin
    mode_next     = mode_reg;
    nmi_rise_next = nmi_rise_reg;
    enable_next   = enable_reg;
    mask_next     = mask_reg;
    sense_next    = sense_reg;
    prio_next     = prio_reg;
    if (wr_en) begin
      case (wr_ofs)
        OFS_SYSTEM_CONTROL: begin
          mode_next     = wr_byte[MODE_LSB +: 2];
          nmi_rise_next = wr_byte[NMI_EDGE_BIT];
        end
        OFS_SENSE_HIGH: begin
          sense_next[4] = wr_byte[1:0];
          sense_next[5] = wr_byte[3:2];
        end
        OFS_SENSE_LOW: begin
          for (int k = 0; k < 4; k++) begin
            sense_next[k] = wr_byte[2 * k +: 2];
          end
        end
        OFS_REQ_ENABLE: enable_next = wr_byte[5:0];
        OFS_INT_MASK:   mask_next   = wr_byte[6:0];
        default: begin
          if (wr_ofs >= OFS_PRIO_FIRST && wr_ofs <= OFS_PRIO_LAST) begin
            prio_next[2 * (addr_reg - 6'h10)]     = wr_byte[PRIO_HIGH_LSB +: 3];
            prio_next[2 * (addr_reg - 6'h10) + 1] = wr_byte[PRIO_LOW_LSB +: 3];
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg     <= MODE_RESET;
      nmi_rise_reg <= 1'b0;
      enable_reg   <= ENABLE_RESET;
      mask_reg     <= 7'h00;
      for (int k = 0; k < NUM_EXT; k++) begin
        sense_reg[k] <= SENSE_RESET;
      end
      for (int k = 0; k < NUM_SRC; k++) begin
        prio_reg[k] <= PRIO_FIELD_RESET;
      end
    end else begin
      mode_reg     <= mode_next;
      nmi_rise_reg <= nmi_rise_next;
      enable_reg   <= enable_next;
      mask_reg     <= mask_next;
      sense_reg    <= sense_next;
      prio_reg     <= prio_next;
    end
  end

  // Flags and sticky status: a set in the same cycle as a clear wins
  always_comb begin
    logic [6:0] ack_clr;
    ack_clr = 7'h00;
    if (cpu_ack && cpu_req_reg) begin
      if (cpu_vector_reg == VEC_NMI) begin
        ack_clr[NMI_STATUS_BIT] = 1'b1;
      end
      for (int k = 0; k < NUM_EXT; k++) begin
        if (cpu_vector_reg == VEC_EXT_BASE + 7'(k) && sense_reg[k] != SENSE_LOW) begin
          ack_clr[k] = 1'b1; // Level sources stay flagged while the pin is low
        end
      end
    end
    flag_next     = flag_reg & ~ack_clr[5:0];
    status_next   = status_reg;
    nmi_pend_next = (nmi_pend_reg & ~ack_clr[NMI_STATUS_BIT]) | nmi_hit;
    if (wr_en && wr_ofs == OFS_REQ_FLAG) begin
      flag_next = flag_next & ~wr_byte[5:0];
    end
    if (wr_en && wr_ofs == OFS_INT_STATUS) begin
      status_next = status_reg & ~wr_byte[6:0];
    end
    flag_next   = flag_next | ext_hit;
    status_next = status_next | {nmi_hit, ext_hit};
    irq_out_next = |(status_reg & mask_reg);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg     <= 6'h00;
      status_reg   <= 7'h00;
      nmi_pend_reg <= 1'b0;
      irq_out_reg  <= 1'b0;
    end else begin
      flag_reg     <= flag_next;
      status_reg   <= status_next;
      nmi_pend_reg <= nmi_pend_next;
      irq_out_reg  <= irq_out_next;
    end
  end

  // Qualified sources: external pins first, then on-chip requests
  assign src_req = {periph_req, flag_reg & enable_reg};

  // Resolution; mode 0 ignores the level fields and uses the fixed order only
  always_comb begin
    logic       found;
    logic [2:0] best_lvl;
    logic [4:0] best_idx;
    logic [2:0] lvl;
    found    = 1'b0;
    best_lvl = 3'h0;
    best_idx = 5'h00;
    lvl      = 3'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      lvl = mode2 ? prio_reg[i] : 3'h0;
      if (src_req[i] && (!found || lvl > best_lvl)) begin
        found    = 1'b1;
        best_lvl = lvl;
        best_idx = 5'(i);
      end
    end
    cpu_req_next    = 1'b0;
    cpu_vector_next = cpu_vector_reg;
    cpu_level_next  = cpu_level_reg;
    if (nmi_pend_reg) begin
      cpu_req_next    = 1'b1;
      cpu_vector_next = VEC_NMI;
      cpu_level_next  = LEVEL_NMI;
    end else if (found) begin
      cpu_req_next    = 1'b1;
      cpu_level_next  = {1'b0, best_lvl};
      cpu_vector_next = (best_idx < 5'(NUM_EXT)) ? VEC_EXT_BASE + {2'b00, best_idx}
                                                 : VEC_PERIPH_BASE + {2'b00, best_idx} - 7'(NUM_EXT);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_req_reg    <= 1'b0;
      cpu_vector_reg <= 7'h00;
      cpu_level_reg  <= 4'h0;
    end else begin
      cpu_req_reg    <= cpu_req_next;
      cpu_vector_reg <= cpu_vector_next;
      cpu_level_reg  <= cpu_level_next;
    end
  end

  assign hreadyout  = hreadyout_reg;
  assign hresp      = hresp_reg;
  assign hrdata     = hrdata_reg;
  assign cpu_req    = cpu_req_reg;
  assign cpu_vector = cpu_vector_reg;
  assign cpu_level  = cpu_level_reg;
  assign irq_out    = irq_out_reg;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_NMI_TOP: assert property (nmi_pend_reg |=> cpu_req_reg && cpu_vector_reg == VEC_NMI
                                && cpu_level_reg == LEVEL_NMI)
    else $error("pending non-maskable request not presented at level 8");
  AST_VEC_UNIQUE: assert property (cpu_req_reg && cpu_vector_reg != VEC_NMI
                                   |-> cpu_vector_reg >= VEC_EXT_BASE && (cpu_vector_reg < VEC_PERIPH_BASE
                                   || |($past(periph_req) & (14'h0001 << (cpu_vector_reg - VEC_PERIPH_BASE)))))
    else $error("maskable request presented with a reserved vector");
  AST_NMI_EDGE: assert property (nmi_rise_reg && $rose(nmi_pin) |=> nmi_pend_reg)
    else $error("selected non-maskable edge missed");
  AST_FALL_FLAG: assert property (sense_reg[0] == SENSE_FALL && $fell(external_request_pins[0])
                                  |=> flag_reg[0])
    else $error("falling edge on pin 0 did not set its flag");
  AST_PRIO_RSVD: assert property ($fell(hreadyout_reg) ##1 (addr_reg >= 6'h10 && addr_reg <= 6'h19)
                                  |=> hrdata_reg[7] == 1'b0 && hrdata_reg[3] == 1'b0)
    else $error("reserved priority bit read as one");
  AST_LEVEL_FLAG: assert property (sense_reg[0] == SENSE_LOW && !external_request_pins[0]
                                   |=> flag_reg[0])
    else $error("low level on pin 0 did not set its flag");
  AST_GATED: assert property (cpu_req_reg && cpu_vector_reg >= VEC_EXT_BASE
                              && cpu_vector_reg < VEC_PERIPH_BASE && !$past(nmi_pend_reg)
                              |-> |($past(flag_reg & enable_reg) & (6'h01 << cpu_vector_reg[2:0])))
    else $error("external request presented without flag and enable");
  AST_MODE0_LVL: assert property (!mode2 && !nmi_pend_reg && |src_req |=> cpu_level_reg == 4'h0)
    else $error("mode 0 presented a nonzero level");
  AST_RD_WAIT: assert property (take && !hwrite && bus_state_reg != PICC_BUS_RDWAIT
                                |=> !hreadyout_reg ##1 hreadyout_reg)
    else $error("read answer not after exactly one wait");
  AST_WIN_LEVEL: assert property (mode2 && src_req[0] && !nmi_pend_reg
                                  |=> cpu_level_reg >= {1'b0, $past(prio_reg[0])})
    else $error("presented level below a pending source");

  COV_NMI: cover property (nmi_pend_reg ##1 cpu_ack);
  COV_EXT: cover property (cpu_req_reg && cpu_vector_reg == VEC_EXT_BASE);
  COV_PERIPH: cover property (mode2 && cpu_req_reg && cpu_vector_reg >= VEC_PERIPH_BASE);
  COV_IRQ: cover property ($rose(irq_out_reg));

endmodule : picc_controller
`default_nettype wire

/* File: src/picc_pkg.sv */
// Package: offsets, field layouts, reset values, codes and types of the interrupt controller
package picc_pkg;

  // Source counts
  localparam int NUM_EXT       = 6;
  localparam int NUM_PRIO_REGS = 10;
  localparam int NUM_SRC       = 2 * NUM_PRIO_REGS;
  localparam int NUM_PERIPH    = NUM_SRC - NUM_EXT;

  // Register byte offsets (word index is offset / 4)
  localparam logic [7:0] OFS_SYSTEM_CONTROL = 8'h00;
  localparam logic [7:0] OFS_SENSE_HIGH     = 8'h04;
  localparam logic [7:0] OFS_SENSE_LOW      = 8'h08;
  localparam logic [7:0] OFS_REQ_ENABLE     = 8'h0C;
  localparam logic [7:0] OFS_REQ_FLAG       = 8'h10;
  localparam logic [7:0] OFS_INT_MASK       = 8'h14;
  localparam logic [7:0] OFS_PRESENTED      = 8'h18;
  localparam logic [7:0] OFS_INT_STATUS     = 8'h1C;
  localparam logic [7:0] OFS_PRIO_FIRST     = 8'h40;
  localparam logic [7:0] OFS_PRIO_LAST      = 8'h64;

  // Field positions
  localparam int MODE_LSB       = 0;
  localparam int NMI_EDGE_BIT   = 2;
  localparam int PRIO_LOW_LSB   = 0;
  localparam int PRIO_HIGH_LSB  = 4;
  localparam int NMI_STATUS_BIT = 6;
  localparam int PRES_LEVEL_LSB = 8;
  localparam int PRES_REQ_BIT   = 12;

  // Reset values
  localparam logic [2:0] PRIO_FIELD_RESET = 3'h7;
  localparam logic [5:0] ENABLE_RESET     = 6'h00;
  localparam logic [1:0] MODE_RESET       = 2'h0;
  localparam logic [1:0] SENSE_RESET      = 2'h0;

  // Mode-select codes
  localparam logic [1:0] MODE_SEL_0 = 2'h0;
  localparam logic [1:0] MODE_SEL_2 = 2'h2;

  // Sense-control codes
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_RISE = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;

  // Vector numbers and levels
  localparam logic [6:0] VEC_NMI         = 7'h07;
  localparam logic [6:0] VEC_EXT_BASE    = 7'h10;
  localparam logic [6:0] VEC_PERIPH_BASE = 7'h18;
  localparam logic [3:0] LEVEL_NMI       = 4'h8;

  // Bus slave states
  typedef enum logic [1:0] {
    PICC_BUS_IDLE,
    PICC_BUS_WRITE,
    PICC_BUS_RDWAIT
  } picc_bus_state_type;

endpackage : picc_pkg

/* File: src/picc_sense_detect.sv */
// Edge or level detector for one request pin
`timescale 1ns/10ps
`default_nettype none
module picc_sense_detect
  import picc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       pin_level,
  input  wire logic [1:0] sense_sel,
  output logic            event_hit
);

  logic prev_reg;
  logic prev_next;
  logic armed_reg;
  logic armed_next;

  // Previous pin level; the first edge after reset only learns it, whatever the pin's idle level
  always_comb begin
    prev_next  = pin_level;
    armed_next = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg  <= 1'b1;
      armed_reg <= 1'b0;
    end else begin
      prev_reg  <= prev_next;
      armed_reg <= armed_next;
    end
  end

  // Selected condition; edges wait for the learnt level, low level does not
  always_comb begin
    case (sense_sel)
      SENSE_LOW:  event_hit = ~pin_level;
      SENSE_FALL: event_hit = armed_reg & prev_reg & ~pin_level;
      SENSE_RISE: event_hit = armed_reg & ~prev_reg & pin_level;
      SENSE_BOTH: event_hit = armed_reg & (prev_reg ^ pin_level);
      default:    event_hit = 1'b0;
    endcase
  end

endmodule : picc_sense_detect
`default_nettype wire

/* File: test/picc_cpu_model.sv */
// CPU core model that accepts presented interrupt vectors
`timescale 1ns/10ps
`default_nettype none
module picc_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ack_en,
  input  wire logic [7:0] ack_delay,
  input  wire logic       cpu_req,
  input  wire logic [6:0] cpu_vector,
  input  wire logic [3:0] cpu_level,
  output logic            cpu_ack,
  output logic [6:0]      taken_vector,
  output logic [3:0]      taken_level,
  output logic [7:0]      taken_cnt
);
  int cnt;
  // Acks after a chosen delay, then rests so a cleared request has time to drop
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_ack <= 1'b0;
      cnt <= 0;
      taken_cnt <= 8'h00;
      taken_vector <= 7'h00;
      taken_level <= 4'h0;
    end else if (cpu_ack) begin
      cpu_ack <= 1'b0;
      taken_vector <= cpu_vector;
      taken_level <= cpu_level;
      taken_cnt <= taken_cnt + 8'h01;
    end else if (cnt < 0) begin
      cnt <= cnt + 1;
    end else if (ack_en && cpu_req) begin
      if (cnt >= int'(ack_delay)) begin
        cpu_ack <= 1'b1;
        cnt <= -3;
      end else begin
        cnt <= cnt + 1;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule : picc_cpu_model
`default_nettype wire

/* File: test/priority_interrupt_controller_test.sv */
// Self-checking testbench of the priority interrupt controller
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %0t: got %h expected %h", $time, got, exp); end end
module priority_interrupt_controller_test;
  import picc_pkg::*;
  logic                  hclk = 1'b0;
  logic                  hresetn, hsel, hwrite, hreadyout, hresp, nmi_pin;
  logic [31:0]           haddr, hwdata, hrdata;
  logic [1:0]            htrans;
  logic [NUM_EXT-1:0]    ext_pins;
  logic [NUM_PERIPH-1:0] periph_req;
  logic                  cpu_ack, cpu_req, irq_out, ack_en;
  logic [6:0]            cpu_vector, taken_vector;
  logic [3:0]            cpu_level, taken_level;
  logic [7:0]            ack_delay, taken_cnt;
  int                    failures = 0;
  int                    n_tests = 0;

  always #4 hclk = ~hclk;

  picc_controller picc_controller_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .nmi_pin(nmi_pin),
    .external_request_pins(ext_pins), .periph_req(periph_req), .cpu_ack(cpu_ack),
    .cpu_req(cpu_req), .cpu_vector(cpu_vector), .cpu_level(cpu_level), .irq_out(irq_out));

  picc_cpu_model picc_cpu_model_i (.clk(hclk), .rst_n(hresetn), .ack_en(ack_en), .ack_delay(ack_delay),
    .cpu_req(cpu_req), .cpu_vector(cpu_vector), .cpu_level(cpu_level), .cpu_ack(cpu_ack),
    .taken_vector(taken_vector), .taken_level(taken_level), .taken_cnt(taken_cnt));

  function automatic logic [31:0] ofs(input logic [7:0] o);
    return {24'h000000, o};
  endfunction : ofs

  // Bounded wait for hready; a hang is reported rather than blocking the run
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      $display("[ERR] %0t: bus hang", $time);
    end
  endtask : wait_ready

  task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask : ahb_write

  task automatic ahb_read(input logic [31:0] a, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    wait_ready();
    d = hrdata;
    `CHECK(hresp, 1'b0)
  endtask : ahb_read

  task automatic wait_taken(input logic [7:0] n);
    for (int k = 0; k < 100 && taken_cnt != n; k++) @(posedge hclk);
    ack_en <= 1'b0;
    `CHECK(taken_cnt, n)
  endtask : wait_taken

  // Reset values, reserved bits, low address bits and an unmapped place
  task automatic t_regs();
    logic [31:0] d;
    for (int n = 0; n < NUM_PRIO_REGS; n++) begin
      ahb_read(32'h40 + 32'(4 * n), d);
      `CHECK(d, 32'h77)
      ahb_write(32'h40 + 32'(4 * n), 32'h88 | 32'(n % 8) << 4 | 32'(7 - n % 8));
      ahb_read(32'h42 + 32'(4 * n), d);
      `CHECK(d, 32'(n % 8) << 4 | 32'(7 - n % 8))
    end
    ahb_read(ofs(OFS_REQ_ENABLE), d);
    `CHECK(d, 32'h0)
    ahb_write(ofs(OFS_REQ_ENABLE), 32'h3F); // Top two bits left at zero
    ahb_read(ofs(OFS_REQ_ENABLE), d);
    `CHECK(d, 32'h3F)
    ahb_write(ofs(OFS_SENSE_HIGH), 32'hFF);
    ahb_read(ofs(OFS_SENSE_HIGH), d);
    `CHECK(d, 32'hF)
    ahb_write(ofs(OFS_SENSE_HIGH), 32'h0);
    ahb_write(32'h80, 32'hFF);
    ahb_read(32'h80, d);
    `CHECK(d, 32'h0)
    $display("t_regs done");
  endtask : t_regs

  // Every sense code on pin 0: falling, then rising, then idle high
  task automatic t_sense();
    logic [31:0] d;
    for (int c = 0; c < 4; c++) begin
      ahb_write(ofs(OFS_SENSE_LOW), 32'(c));
      ahb_write(ofs(OFS_REQ_FLAG), 32'h3F);
      @(posedge hclk);
      ext_pins[0] <= 1'b0;
      repeat (3) @(posedge hclk);
      ahb_read(ofs(OFS_REQ_FLAG), d);
      `CHECK(d, {31'h0, c != 2})
      ahb_write(ofs(OFS_REQ_FLAG), 32'h3F);
      ext_pins[0] <= 1'b1;
      repeat (3) @(posedge hclk);
      ahb_read(ofs(OFS_REQ_FLAG), d);
      `CHECK(d, {31'h0, c != 1})
      ahb_write(ofs(OFS_REQ_FLAG), 32'h3F);
      ahb_read(ofs(OFS_REQ_FLAG), d);
      `CHECK(d, 32'h0)
    end
    // Sticky status drives the interrupt line only through the mask
    ahb_write(ofs(OFS_INT_MASK), 32'h0);
    repeat (2) @(posedge hclk);
    `CHECK(irq_out, 1'b0)
    ahb_write(ofs(OFS_INT_MASK), 32'h1);
    repeat (2) @(posedge hclk);
    `CHECK(irq_out, 1'b1)
    ahb_write(ofs(OFS_INT_STATUS), 32'h7F);
    repeat (2) @(posedge hclk);
    `CHECK(irq_out, 1'b0)
    $display("t_sense done");
  endtask : t_sense

  // Modes, levels, ties, enables and peripheral requests, then slow acks
  task automatic t_prio();
    ahb_write(ofs(OFS_SENSE_LOW), 32'h5);
    ahb_write(32'h40, 32'h15);
    ahb_write(32'h4C, 32'h70);
    ahb_write(ofs(OFS_REQ_FLAG), 32'h3F);
    @(posedge hclk);
    ext_pins <= 6'h3C;
    for (int i = 0; i < 4; i++) begin
      ahb_write(ofs(OFS_SYSTEM_CONTROL), 32'(i));
      repeat (3) @(posedge hclk);
      `CHECK(cpu_vector, (i == 2) ? 7'h11 : 7'h10)
      `CHECK(cpu_level, (i == 2) ? 4'h5 : 4'h0)
    end
    ahb_write(ofs(OFS_SYSTEM_CONTROL), 32'h2);
    ahb_write(32'h40, 32'h33);
    repeat (3) @(posedge hclk);
    `CHECK(cpu_vector, 7'h10)
    ahb_write(ofs(OFS_REQ_ENABLE), 32'h2);
    repeat (3) @(posedge hclk);
    `CHECK(cpu_vector, 7'h11)
    periph_req[0] <= 1'b1;
    repeat (3) @(posedge hclk);
    `CHECK(cpu_vector, VEC_PERIPH_BASE)
    `CHECK(cpu_level, 4'h7)
    ahb_write(32'h4C, 32'h07);
    repeat (3) @(posedge hclk);
    `CHECK(cpu_vector, 7'h11)
    periph_req[0] <= 1'b0;
    ahb_write(ofs(OFS_REQ_ENABLE), 32'h3);
    ack_delay <= 8'd4;
    ack_en <= 1'b1;
    wait_taken(8'd1);
    `CHECK(taken_vector, 7'h10)
    ack_en <= 1'b1;
    wait_taken(8'd2);
    `CHECK(taken_vector, 7'h11)
    repeat (6) @(posedge hclk);
    `CHECK(cpu_req, 1'b0)
    ext_pins <= 6'h3F;
    $display("t_prio done");
  endtask : t_prio

  // Non-maskable input on each selected edge, above every settable level
  task automatic t_nmi();
    logic [31:0] d;
    ahb_write(ofs(OFS_SYSTEM_CONTROL), 32'h6);
    ahb_write(ofs(OFS_INT_MASK), 32'h0);
    ahb_write(32'h4C, 32'h70);
    @(posedge hclk);
    periph_req[0] <= 1'b1;
    nmi_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    `CHECK(cpu_vector, VEC_NMI)
    `CHECK(cpu_level, LEVEL_NMI)
    ahb_read(ofs(OFS_PRESENTED), d);
    `CHECK(d, 32'h1807)
    ahb_read(ofs(OFS_INT_STATUS), d);
    `CHECK(d[NMI_STATUS_BIT], 1'b1)
    ack_delay <= 8'd0;
    ack_en <= 1'b1;
    wait_taken(8'd3);
    `CHECK(taken_level, LEVEL_NMI)
    nmi_pin <= 1'b0;
    repeat (4) @(posedge hclk);
    `CHECK(cpu_vector, VEC_PERIPH_BASE)
    ahb_write(ofs(OFS_SYSTEM_CONTROL), 32'h2);
    nmi_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    `CHECK(cpu_vector, VEC_PERIPH_BASE)
    nmi_pin <= 1'b0;
    repeat (3) @(posedge hclk);
    `CHECK(cpu_vector, VEC_NMI)
    periph_req[0] <= 1'b0;
    $display("t_nmi done");
  endtask : t_nmi

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence: reset for 16 cycles, then the scenarios in turn
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    nmi_pin = 1'b0;
    ext_pins = 6'h3F;
    periph_req = '0;
    ack_en = 1'b0;
    ack_delay = 8'd0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_sense();
    t_prio();
    t_nmi();
    tally_and_finish();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    tally_and_finish();
  end
endmodule : priority_interrupt_controller_test
`default_nettype wire
